// ### src/pll_feed_and_status_control.sv
`timescale 1ns/1ns
// Summary of operation
// RULE1: status bits 4:0 return the applied multiplier from the shadow, reset zero.
// RULE2: status bits 6:5 return the applied divider from the shadow, reset zero.
// RULE3: status bit 8 shows the effective enable, reset zero.
// RULE4: status bit 9 shows effective connect; PLL clocks system only if both set.
// RULE5: status bit 10 reflects the lock indication, reset zero.
// RULE6: the lock status also drives an interrupt request line.
// RULE7: on lock interrupt software may connect and then disable that interrupt.
// RULE8: connect without enable behaves as both clear: off and disconnected.
// RULE9: enable alone runs the PLL unselected; software connects only after lock.
// RULE10: holding values take effect only after feed writes 0xAA then 0x55.
// RULE11: both feed writes must be consecutive bus cycles; any other cycle voids.
// RULE12: software keeps interrupts disabled during the feed pair.
// RULE13: a wrong value or broken sequence leaves effective settings unchanged.
// RULE14: feed location is 8-bit write-only, used only to detect the sequence.
// RULE15: entering power-down clears effective enable and connect.
// RULE16: wakeup does not restore enable or connect.
// RULE17: after wakeup software enables, awaits lock, then connects; no blind feed.
// RULE18: output clock is multiplier times oscillator; internal runs at 2 times divider more.
// RULE19: software keeps oscillator 10-25 MHz and internal oscillator 156-320 MHz.
// RULE20: control and config are holding registers copied to shadows by a feed.
// RULE21: control holding has enable in bit 0 and connect in bit 1, reset zero.
// RULE22: multiplier field is value minus one; divider codes 0..3 mean 1,2,4,8.
// RULE23: after an accepted 0xAA, any cycle but a 0x55 feed write returns to idle.
// RULE24: reserved status bits read zero and status writes are ignored.
module pll_feed_and_status_control (
  // clock, reset and clock enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // peripheral bus, one request per bus cycle
  input wire pll_ctrl_pkg::bus_req_s bus_req,
  output logic [31:0] bus_rdata,
  output logic bus_rvalid,
  // analog and power interface
  input wire logic lock_indicator,
  input wire logic power_down_bit,
  // shadow outputs driving the PLL
  output logic pll_run,
  output logic pll_select,
  output pll_ctrl_pkg::pll_cfg_s pll_cfg,
  output logic [5:0] mul_factor,
  output logic [3:0] div_factor,
  // interrupt controller request
  output logic lock_irq
);
  import pll_ctrl_pkg::*;

  logic enable_hold_q;
  logic connect_hold_q;
  pll_cfg_s cfg_hold_q;
  logic enable_eff_q;
  logic connect_eff_q;
  pll_cfg_s cfg_eff_q;
  logic lock_q;
  logic pd_q;
  logic run_q;
  logic select_q;
  logic [5:0] mul_q;
  logic [3:0] div_q;
  logic irq_q;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic feed_ok;
  logic pd_entry;
  logic wr_cycle;
  logic rd_cycle;
  logic [STATUS_W-1:0] status_word;

  // decoded bus cycle kinds
  assign wr_cycle = bus_req.cycle && bus_req.write;
  assign rd_cycle = bus_req.cycle && !bus_req.write;
  assign pd_entry = power_down_bit && !pd_q;

  // RULE11: sequence detector sees every cycle
  pll_feed_detect u_feed (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .bus_cycle(bus_req.cycle),
    .feed_write(wr_cycle && bus_req.addr == ADDR_UNLOCK_SEQUENCE),
    .feed_data(bus_req.wdata[7:0]),
    .feed_ok(feed_ok)
  );

  // control holding register written by software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enable_hold_q <= 1'b0;
      connect_hold_q <= 1'b0;
    end else if (ce && wr_cycle && bus_req.addr == ADDR_CONTROL_HOLDING) begin
      // RULE21: enable bit 0, connect bit 1
      enable_hold_q <= bus_req.wdata[ENABLE_POS];
      connect_hold_q <= bus_req.wdata[CONNECT_POS];
    end
  end

  // configuration holding register written by software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_hold_q <= '{div: DIV_RESET, mul: MUL_RESET};
    end else if (ce && wr_cycle && bus_req.addr == ADDR_CONFIG_HOLDING) begin
      cfg_hold_q.mul <= bus_req.wdata[MUL_LSB +: MUL_W];
      cfg_hold_q.div <= bus_req.wdata[DIV_LSB +: DIV_W];
    end
  end

  // power-down level history for entry detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pd_q <= 1'b0;
    end else if (ce) begin
      pd_q <= power_down_bit;
    end
  end

  // shadow enable and connect
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enable_eff_q <= 1'b0;
      connect_eff_q <= 1'b0;
    end else if (ce) begin
      if (pd_entry) begin
        // RULE15: power-down clears effective
        // RULE16: nothing restores on wakeup
        enable_eff_q <= 1'b0;
        connect_eff_q <= 1'b0;
      end else if (feed_ok) begin
        // RULE20: feed copies holding
        enable_eff_q <= enable_hold_q;
        connect_eff_q <= connect_hold_q;
      end
    end
  end

  // shadow configuration, power-down leaves it alone
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_eff_q <= '{div: DIV_RESET, mul: MUL_RESET};
    end else if (ce && feed_ok && !pd_entry) begin
      // RULE13: only a valid feed loads
      cfg_eff_q <= cfg_hold_q;
    end
  end

  // lock sample and interrupt request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce) begin
      // RULE5: lock reflected in status
      lock_q <= lock_indicator;
      // RULE6: lock drives interrupt line
      irq_q <= lock_indicator;
    end
  end

  // registered PLL drive outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      select_q <= 1'b0;
      mul_q <= 6'h01;
      div_q <= 4'h1;
    end else if (ce) begin
      // RULE8: connect needs enable
      // RULE9: enable alone runs unselected
      run_q <= enable_eff_q;
      // RULE4: clock source only when both
      select_q <= enable_eff_q && connect_eff_q;
      // RULE18: factors for output and internal clock
      // RULE22: field encodings decoded
      mul_q <= mul_value(cfg_eff_q.mul);
      div_q <= div_value(cfg_eff_q.div);
    end
  end

  // status word assembly
  always_comb begin
    status_word = '0;
    // RULE1: applied multiplier
    status_word[MUL_LSB +: MUL_W] = cfg_eff_q.mul;
    // RULE2: applied divider
    status_word[DIV_LSB +: DIV_W] = cfg_eff_q.div;
    // RULE3: effective enable
    status_word[STAT_ENABLE_POS] = enable_eff_q;
    // RULE4: effective connect
    status_word[STAT_CONNECT_POS] = connect_eff_q;
    status_word[STAT_LOCK_POS] = lock_q;
  end

  // read port: data one cycle after the read cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= RDATA_RESET;
      rvalid_q <= 1'b0;
    end else if (ce) begin
      rvalid_q <= rd_cycle;
      if (rd_cycle) begin
        case (bus_req.addr)
          ADDR_CONTROL_HOLDING: begin
            rdata_q <= {30'h0, connect_hold_q, enable_hold_q};
          end
          ADDR_CONFIG_HOLDING: begin
            rdata_q <= {25'h0, cfg_hold_q.div, cfg_hold_q.mul};
          end
          ADDR_ACTIVE_STATUS: begin
            // RULE24: reserved bits zero
            rdata_q <= {16'h0, status_word};
          end
          default: begin
            // RULE14: feed reads as zero
            rdata_q <= RDATA_RESET;
          end
        endcase
      end else begin
        rdata_q <= RDATA_RESET;
      end
    end
  end

  assign bus_rdata = rdata_q;
  assign bus_rvalid = rvalid_q;
  assign pll_run = run_q;
  assign pll_select = select_q;
  assign pll_cfg = cfg_eff_q;
  assign mul_factor = mul_q;
  assign div_factor = div_q;
  assign lock_irq = irq_q;

endmodule

// ### src/pll_ctrl_pkg.sv
package pll_ctrl_pkg;

  // register byte addresses on the peripheral bus
  localparam logic [31:0] ADDR_CONTROL_HOLDING = 32'he01f_c080;
  localparam logic [31:0] ADDR_CONFIG_HOLDING = 32'he01f_c084;
  localparam logic [31:0] ADDR_ACTIVE_STATUS = 32'he01f_c088;
  localparam logic [31:0] ADDR_UNLOCK_SEQUENCE = 32'he01f_c08c;

  // unlock sequence values
  localparam logic [7:0] FEED_FIRST = 8'haa;
  localparam logic [7:0] FEED_SECOND = 8'h55;

  // control holding field positions
  localparam int ENABLE_POS = 0;
  localparam int CONNECT_POS = 1;

  // config and status field positions
  localparam int MUL_LSB = 0;
  localparam int MUL_W = 5;
  localparam int DIV_LSB = 5;
  localparam int DIV_W = 2;
  localparam int STAT_ENABLE_POS = 8;
  localparam int STAT_CONNECT_POS = 9;
  localparam int STAT_LOCK_POS = 10;
  localparam int STATUS_W = 16;

  // reset values
  localparam logic [MUL_W-1:0] MUL_RESET = 5'h0;
  localparam logic [DIV_W-1:0] DIV_RESET = 2'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // multiplier and divider setting as one carrier
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [MUL_W-1:0] mul;
  } pll_cfg_s;

  // one peripheral bus cycle
  typedef struct packed {
    logic cycle;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_s;

  typedef enum logic [0:0] {
    FEED_IDLE,
    FEED_GOT_FIRST
  } feed_state_e;

  // multiplier value 1..32 from its field
  function automatic logic [5:0] mul_value(input logic [MUL_W-1:0] f);
    mul_value = {1'b0, f} + 6'h01;
  endfunction

  // divisor 1, 2, 4 or 8 from its field
  function automatic logic [3:0] div_value(input logic [DIV_W-1:0] f);
    div_value = 4'h1 << f;
  endfunction

endpackage

// ### src/pll_feed_detect.sv
`timescale 1ns/1ns
module pll_feed_detect (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // bus cycle view
  input wire logic bus_cycle,
  input wire logic feed_write,
  input wire logic [7:0] feed_data,
  // accepted sequence
  output logic feed_ok
);
  import pll_ctrl_pkg::*;

  feed_state_e state_q;
  logic ok_q;

  // two-write sequence tracker, every bus cycle advances or voids it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= FEED_IDLE;
    end else if (ce && bus_cycle) begin
      case (state_q)
        FEED_IDLE: begin
          // RULE10: first value arms
          if (feed_write && feed_data == FEED_FIRST) begin
            state_q <= FEED_GOT_FIRST;
          end
        end
        FEED_GOT_FIRST: begin
          // RULE11: next cycle decides
          // RULE23: anything returns idle
          state_q <= FEED_IDLE;
        end
        default: begin
          state_q <= FEED_IDLE;
        end
      endcase
    end
  end

  // one-cycle pulse when the second value follows directly
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ok_q <= 1'b0;
    end else if (ce) begin
      // RULE10: second value completes
      // RULE13: wrong value ignored
      ok_q <= bus_cycle && state_q == FEED_GOT_FIRST && feed_write && feed_data == FEED_SECOND;
    end
  end

  assign feed_ok = ok_q;

endmodule

// ### verification/pll_ctrl_sva.sv
`timescale 1ns/1ns
module pll_ctrl_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // bus side
  input wire pll_ctrl_pkg::bus_req_s bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_rvalid,
  // pll side
  input wire logic lock_indicator,
  input wire logic power_down_bit,
  input wire logic pll_run,
  input wire logic pll_select,
  input wire pll_ctrl_pkg::pll_cfg_s pll_cfg,
  input wire logic [5:0] mul_factor,
  input wire logic [3:0] div_factor,
  input wire logic lock_irq
);
  import pll_ctrl_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic f2;
  logic rs;
  // second feed write and status read seen on the bus
  assign f2 = ce && bus_req.cycle && bus_req.write && bus_req.addr == ADDR_UNLOCK_SEQUENCE
    && bus_req.wdata[7:0] == FEED_SECOND;
  assign rs = ce && bus_req.cycle && !bus_req.write && bus_req.addr == ADDR_ACTIVE_STATUS;
  // power-down entry step
  sequence s_pd_entry;
    ce && $rose(power_down_bit);
  endsequence
  AST_LOCK_IRQ: assert property (ce |=> lock_irq == $past(lock_indicator))
    else $error("lock request wrong");
  AST_SEL_RUN: assert property (pll_select |-> pll_run)
    else $error("selected while off");
  AST_MUL: assert property (ce |=> mul_factor == {1'b0, $past(pll_cfg.mul)} + 6'h01)
    else $error("multiplier wrong");
  AST_DIV: assert property (ce |=> div_factor == 4'h1 << $past(pll_cfg.div))
    else $error("divisor wrong");
  AST_CFG_FEED: assert property ($changed(pll_cfg) |-> $past(f2, 2))
    else $error("config moved without feed");
  AST_RUN_FEED: assert property ($rose(pll_run) |-> $past(f2, 3))
    else $error("enable rose without feed");
  AST_PD_CLEAR: assert property (s_pd_entry |-> ##2 !pll_run && !pll_select)
    else $error("power-down did not clear");
  AST_STAT_RSVD: assert property (rs |=> bus_rvalid && bus_rdata[31:11] == 21'h0 && !bus_rdata[7])
    else $error("reserved status bits set");
endmodule
bind pll_feed_and_status_control pll_ctrl_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .lock_indicator(lock_indicator),
  .power_down_bit(power_down_bit), .pll_run(pll_run), .pll_select(pll_select), .pll_cfg(pll_cfg),
  .mul_factor(mul_factor), .div_factor(div_factor), .lock_irq(lock_irq));

// ### verification/pll_feed_and_status_control_test.sv
`timescale 1ns/1ns
module pll_feed_and_status_control_test;
  import pll_ctrl_pkg::*;
  localparam logic [31:0] F = ADDR_UNLOCK_SEQUENCE;
  localparam logic [31:0] S = ADDR_ACTIVE_STATUS;
  logic clk_sys;
  logic rst_n;
  logic ce;
  bus_req_s bus_req;
  logic [31:0] bus_rdata;
  logic bus_rvalid;
  logic lock_indicator;
  logic power_down_bit;
  logic pll_run;
  logic pll_select;
  pll_cfg_s pll_cfg;
  logic [5:0] mul_factor;
  logic [3:0] div_factor;
  logic lock_irq;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  // ordinary case: control, config, lock, then status, run, select, multiplier, divisor
  typedef struct packed {
    logic [1:0] ctrl;
    logic [6:0] cfg;
    logic lock;
    logic [15:0] stat;
    logic run;
    logic sel;
    logic [5:0] mul;
    logic [3:0] div;
  } row_s;
  // software picks the settings, bench only checks decoding
  row_s rows [4] = '{'{2'h1, 7'h00, 1'b0, 16'h0100, 1'b1, 1'b0, 6'h01, 4'h1},
    '{2'h3, 7'h3f, 1'b1, 16'h073f, 1'b1, 1'b1, 6'h20, 4'h2},
    '{2'h2, 7'h45, 1'b0, 16'h0245, 1'b0, 1'b0, 6'h06, 4'h4},
    '{2'h0, 7'h7e, 1'b0, 16'h007e, 1'b0, 1'b0, 6'h1f, 4'h8}};
  pll_feed_and_status_control u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .lock_indicator(lock_indicator),
    .power_down_bit(power_down_bit), .pll_run(pll_run), .pll_select(pll_select), .pll_cfg(pll_cfg),
    .mul_factor(mul_factor), .div_factor(div_factor), .lock_irq(lock_irq));
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // compare and count
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one bus cycle, held until the edge that takes it
  task automatic cyc(input logic w, input logic [31:0] a, input logic [31:0] d);
    bus_req <= '{1'b1, w, a, d};
    @(posedge clk_sys);
  endtask
  task automatic idle(input int n);
    bus_req.cycle <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask
  // read, answer looked at in the cycle after
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string name);
    cyc(1'b0, a, 32'h0);
    bus_req.cycle <= 1'b0;
    #1;
    chk(name, exp, bus_rdata);
    chk("rvalid", 32'h1, {31'h0, bus_rvalid});
    @(posedge clk_sys);
  endtask
  // the pair goes out back to back, nothing between
  task automatic feed();
    cyc(1'b1, F, 32'haa);
    cyc(1'b1, F, 32'h55);
    idle(4);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    bus_req = '0;
    lock_indicator = 1'b0;
    power_down_bit = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(S, 32'h0, "reset status");
    chk("reset mul", 32'h1, {26'h0, mul_factor});
    foreach (rows[i]) begin
      lock_indicator <= rows[i].lock;
      cyc(1'b1, ADDR_CONTROL_HOLDING, {30'h0, rows[i].ctrl});
      cyc(1'b1, ADDR_CONFIG_HOLDING, {25'h0, rows[i].cfg});
      feed();
      rd(S, {16'h0, rows[i].stat}, "status");
      chk("run", {31'h0, rows[i].run}, {31'h0, pll_run});
      chk("select", {31'h0, rows[i].sel}, {31'h0, pll_select});
      chk("mul", {26'h0, rows[i].mul}, {26'h0, mul_factor});
      chk("div", {28'h0, rows[i].div}, {28'h0, div_factor});
      chk("irq", {31'h0, rows[i].lock}, {31'h0, lock_irq});
    end
    cyc(1'b1, ADDR_CONTROL_HOLDING, 32'h3);
    cyc(1'b1, ADDR_CONFIG_HOLDING, 32'h11);
    rd(ADDR_CONTROL_HOLDING, 32'h3, "control");
    rd(ADDR_CONFIG_HOLDING, 32'h11, "config");
    // broken sequences: read between, wrong value, doubled first value
    cyc(1'b1, F, 32'haa);
    rd(F, 32'h0, "feed read");
    cyc(1'b1, F, 32'h55);
    cyc(1'b1, F, 32'haa);
    cyc(1'b1, F, 32'h56);
    cyc(1'b1, F, 32'h55);
    cyc(1'b1, F, 32'haa);
    cyc(1'b1, F, 32'haa);
    cyc(1'b1, F, 32'h55);
    cyc(1'b1, S, 32'hffff);
    idle(4);
    rd(S, 32'h007e, "status kept");
    rd(32'he01f_c090, 32'h0, "unmapped");
    // idle clocks between the two writes do not void
    cyc(1'b1, F, 32'haa);
    idle(2);
    feed_tail: cyc(1'b1, F, 32'h55);
    idle(4);
    rd(S, 32'h0311, "idle gap feed");
    power_down_bit <= 1'b1;
    idle(4);
    power_down_bit <= 1'b0;
    idle(2);
    rd(S, 32'h0011, "after wake");
    // wake recovery: enable, await lock, then connect
    cyc(1'b1, ADDR_CONTROL_HOLDING, 32'h1);
    feed();
    lock_indicator <= 1'b1;
    idle(2);
    chk("wake irq", 32'h1, {31'h0, lock_irq});
    cyc(1'b1, ADDR_CONTROL_HOLDING, 32'h3);
    feed();
    rd(S, 32'h0711, "reconnect");
    // clock enable low freezes a holding write
    ce <= 1'b0;
    cyc(1'b1, ADDR_CONTROL_HOLDING, 32'h0);
    ce <= 1'b1;
    rd(ADDR_CONTROL_HOLDING, 32'h3, "ce frozen");
    final_report();
  end
endmodule
